// ---- core/icp_pkg.sv ----
// icp_pkg: constants and types for the interrupt controller with pin filter.
// assumes one peripheral clock domain and the system reset.
package icp_pkg;

  // pin counts: eight external pins plus the non-maskable pin at the top
  localparam int NUM_EXT = 8;
  localparam int NUM_PIN = 9;
  localparam int PIN_NMI = 8;

  // vector space
  localparam int NUM_VEC = 256;
  localparam int VEC_W   = 8;
  localparam logic [VEC_W-1:0] IRQ_VEC_BASE = 8'h40;
  localparam logic [VEC_W-1:0] SWI_VEC      = 8'h1B;

  // vector ranges absent on some chip versions
  localparam logic [VEC_W-1:0] SDH_VEC_LO = 8'h28;
  localparam logic [VEC_W-1:0] SDH_VEC_HI = 8'h2B;
  localparam logic [VEC_W-1:0] CAN_VEC_LO = 8'h34;
  localparam logic [VEC_W-1:0] CAN_VEC_HI = 8'h38;
  localparam logic [VEC_W-1:0] SEC_VEC_LO = 8'h6F;
  localparam logic [VEC_W-1:0] SEC_VEC_HI = 8'h71;

  // chip version codes
  localparam logic [1:0] VER_A = 2'h0;
  localparam logic [1:0] VER_B = 2'h1;
  localparam logic [1:0] VER_C = 2'h2;

  // per-pin detection modes
  localparam logic [1:0] DET_LOW  = 2'h0;
  localparam logic [1:0] DET_FALL = 2'h1;
  localparam logic [1:0] DET_RISE = 2'h2;
  localparam logic [1:0] DET_BOTH = 2'h3;

  // filter sample clock selection and divider masks
  localparam int DIV_W = 6;
  localparam logic [1:0] SMP_DIV1  = 2'h0;
  localparam logic [1:0] SMP_DIV8  = 2'h1;
  localparam logic [1:0] SMP_DIV32 = 2'h2;
  localparam logic [1:0] SMP_DIV64 = 2'h3;
  localparam logic [DIV_W-1:0] MASK_DIV1  = 6'h00;
  localparam logic [DIV_W-1:0] MASK_DIV8  = 6'h07;
  localparam logic [DIV_W-1:0] MASK_DIV32 = 6'h1F;
  localparam logic [DIV_W-1:0] MASK_DIV64 = 6'h3F;

  // filter depth and idle pin level
  localparam int FLT_DEPTH = 3;
  localparam logic [FLT_DEPTH-1:0] FLT_ALL_HI = 3'h7;
  localparam logic [FLT_DEPTH-1:0] FLT_ALL_LO = 3'h0;
  localparam logic [NUM_PIN-1:0]   PIN_IDLE   = 9'h1FF;

  // non-maskable source bits
  localparam int NMI_SRC  = 7;
  localparam int NMI_PIN  = 0;
  localparam int NMI_OSC  = 1;
  localparam int NMI_WDT  = 2;
  localparam int NMI_IWDT = 3;
  localparam int NMI_LVD1 = 4;
  localparam int NMI_LVD2 = 5;
  localparam int NMI_VBAT = 6;

  // exception codes
  localparam int TRAP_W = 4;
  localparam logic [1:0] EXC_NONE  = 2'h0;
  localparam logic [1:0] EXC_UNDEF = 2'h1;
  localparam logic [1:0] EXC_BREAK = 2'h2;
  localparam logic [1:0] EXC_TRAP  = 2'h3;

  typedef struct packed {
    logic              valid;
    logic [1:0]        code;
    logic [TRAP_W-1:0] num;
  } icp_exc_t;

  typedef struct packed {
    logic [FLT_DEPTH-1:0] samp;
    logic                 lvl;
  } icp_flt_state_t;

  typedef struct packed {
    logic [DIV_W-1:0]   div_cnt;
    logic               tick;
    logic [NUM_PIN-1:0] prev_lvl;
    logic [NUM_VEC-1:0] flags;
    logic [NMI_SRC-1:0] nmi_flags;
    logic               nmi_req;
    logic               irq_valid;
    logic [VEC_W-1:0]   irq_vec;
    icp_exc_t           exc;
  } icp_state_t;

endpackage

// ---- core/icp_pin_filter.sv ----
// icp_pin_filter: three-sample digital noise filter for one pin.
// assumes a one-cycle sample tick from the parent and a synchronous pin.
`timescale 1ns/1ps
`default_nettype none

module icp_pin_filter (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  // control
  input  wire logic sample_tick_i,
  input  wire logic filter_en_i,
  // pin and result
  input  wire logic pin_i,
  output logic      level_o
);

  icp_pkg::icp_flt_state_t st_reg;
  icp_pkg::icp_flt_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (!filter_en_i) begin
      // bypass; samples follow the pin so re-enabling starts clean
      st_next.lvl  = pin_i;
      st_next.samp = {icp_pkg::FLT_DEPTH{pin_i}};
    end else if (sample_tick_i) begin
      st_next.samp = {st_reg.samp[icp_pkg::FLT_DEPTH-2:0], pin_i};
      if (st_next.samp == icp_pkg::FLT_ALL_HI ||
          st_next.samp == icp_pkg::FLT_ALL_LO) begin
        st_next.lvl = pin_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg.samp <= icp_pkg::FLT_ALL_HI;
      st_reg.lvl  <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_o = st_reg.lvl;

  a_flt_bypass: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !filter_en_i |=> level_o == $past(pin_i))
    else $error("bypassed filter did not pass pin through");

  a_flt_hold: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    filter_en_i && !sample_tick_i |=> $stable(level_o))
    else $error("filtered level changed without a sample");

  a_flt_three: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    filter_en_i && $changed(level_o) && $past(filter_en_i)
      |-> st_reg.samp == {icp_pkg::FLT_DEPTH{level_o}})
    else $error("level accepted before three equal samples");

endmodule
`default_nettype wire

// ---- core/icp_top.sv ----
// icp_top: interrupt controller with pin filters, edge/level detect,
// non-maskable sources, peripheral and software vectors, exceptions.
// assumes all inputs synchronous to ref_clk_i; chip version is static.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - pin, osc stop, watchdogs, voltage are non-maskable
// - filter on nmi pin and eight external pins
// - accept level after three equal samples
// - sample clock is pclk, /8, /32 or /64
// - each filter enable per pin; off passes raw
// - rising edge selectable on nmi and external pins
// - falling edge selectable on nmi and external pins
// - both edges only on external pins
// - low level only external; request persists while low
// - exactly one software interrupt source
// - trap and break raise traps, 16 trap numbers
// - undefined opcode raises its own exception
// - versions A, C lack vectors 40-43, 111-113
// - version C lacks vectors 52-56
module icp_top (
  // clock and reset
  input  wire logic                         ref_clk_i,
  input  wire logic                         rst_i,
  // configuration
  input  wire logic [1:0]                   chip_ver_i,
  input  wire logic [1:0]                   div_sel_i,
  input  wire logic [icp_pkg::NUM_PIN-1:0]  filter_en_i,
  input  wire logic [2*icp_pkg::NUM_EXT-1:0] ext_mode_i,
  input  wire logic                         nmi_rise_i,
  // pins
  input  wire logic [icp_pkg::NUM_EXT-1:0]  external_irq_pins_i,
  input  wire logic                         nmi_pin_i,
  // non-maskable sources
  input  wire logic                         osc_stop_i,
  input  wire logic                         wdt_err_i,
  input  wire logic                         iwdt_err_i,
  input  wire logic                         lvd1_i,
  input  wire logic                         lvd2_i,
  input  wire logic                         vbat_i,
  input  wire logic [icp_pkg::NMI_SRC-1:0]  nmi_clear_i,
  // maskable sources
  input  wire logic [icp_pkg::NUM_VEC-1:0]  periph_req_i,
  input  wire logic [icp_pkg::NUM_VEC-1:0]  irq_en_i,
  input  wire logic                         sw_trigger_i,
  // cpu acknowledge
  input  wire logic                         irq_ack_i,
  input  wire logic [icp_pkg::VEC_W-1:0]    irq_ack_vec_i,
  // cpu exception sources
  input  wire logic                         trap_i,
  input  wire logic [icp_pkg::TRAP_W-1:0]   trap_num_i,
  input  wire logic                         break_instruction_i,
  input  wire logic                         undef_i,
  // to cpu
  output logic                              irq_valid_o,
  output logic [icp_pkg::VEC_W-1:0]         irq_vec_o,
  output logic                              nmi_o,
  output logic [icp_pkg::NMI_SRC-1:0]       nmi_status_o,
  output icp_pkg::icp_exc_t                 exc_o,
  output logic [icp_pkg::NUM_PIN-1:0]       pin_level_o
);

  icp_pkg::icp_state_t                st_reg;
  icp_pkg::icp_state_t                st_next;
  logic [icp_pkg::NUM_PIN-1:0]        raw_pin;
  logic [icp_pkg::NUM_PIN-1:0]        flt_lvl;
  logic [icp_pkg::NUM_PIN-1:0]        rise;
  logic [icp_pkg::NUM_PIN-1:0]        fall;
  logic [icp_pkg::NUM_EXT-1:0]        ext_hit;
  logic [icp_pkg::NUM_VEC-1:0]        impl_mask;
  logic [icp_pkg::NUM_VEC-1:0]        set_vec;
  logic [icp_pkg::NUM_VEC-1:0]        clr_vec;
  logic [icp_pkg::NMI_SRC-1:0]        nmi_set;
  logic [icp_pkg::DIV_W-1:0]          div_mask;
  logic                               nmi_edge;
  logic                               ver_ac;
  logic                               ver_c;
  logic                               found;
  logic [icp_pkg::VEC_W-1:0]          pick;

  assign raw_pin = {nmi_pin_i, external_irq_pins_i};

  // one filter per pin; the nmi pin sits at the top index
  for (genvar p = 0; p < icp_pkg::NUM_PIN; p++) begin : g_flt
    icp_pin_filter u_flt (
      .ref_clk_i     (ref_clk_i),
      .rst_i         (rst_i),
      .sample_tick_i (st_reg.tick),
      .filter_en_i   (filter_en_i[p]),
      .pin_i         (raw_pin[p]),
      .level_o       (flt_lvl[p])
    );
  end

  // sample divider mask
  always_comb begin
    unique case (div_sel_i)
      icp_pkg::SMP_DIV1:  div_mask = icp_pkg::MASK_DIV1;
      icp_pkg::SMP_DIV8:  div_mask = icp_pkg::MASK_DIV8;
      icp_pkg::SMP_DIV32: div_mask = icp_pkg::MASK_DIV32;
      icp_pkg::SMP_DIV64: div_mask = icp_pkg::MASK_DIV64;
    endcase
  end

  // implemented-vector mask; gated at flag and at selection
  assign ver_ac = (chip_ver_i == icp_pkg::VER_A) ||
                  (chip_ver_i == icp_pkg::VER_C);
  assign ver_c  = (chip_ver_i == icp_pkg::VER_C);

  always_comb begin
    for (int v = 0; v < icp_pkg::NUM_VEC; v++) begin
      impl_mask[v] = 1'b1;
      if (ver_ac && v >= int'(icp_pkg::SDH_VEC_LO) &&
          v <= int'(icp_pkg::SDH_VEC_HI)) begin
        impl_mask[v] = 1'b0;
      end
      if (ver_ac && v >= int'(icp_pkg::SEC_VEC_LO) &&
          v <= int'(icp_pkg::SEC_VEC_HI)) begin
        impl_mask[v] = 1'b0;
      end
      if (ver_c && v >= int'(icp_pkg::CAN_VEC_LO) &&
          v <= int'(icp_pkg::CAN_VEC_HI)) begin
        impl_mask[v] = 1'b0;
      end
    end
  end

  // edge and level detection on filtered levels
  assign rise = flt_lvl & ~st_reg.prev_lvl;
  assign fall = ~flt_lvl & st_reg.prev_lvl;

  always_comb begin
    for (int i = 0; i < icp_pkg::NUM_EXT; i++) begin
      unique case (ext_mode_i[2*i +: 2])
        icp_pkg::DET_LOW:  ext_hit[i] = ~flt_lvl[i];
        icp_pkg::DET_FALL: ext_hit[i] = fall[i];
        icp_pkg::DET_RISE: ext_hit[i] = rise[i];
        icp_pkg::DET_BOTH: ext_hit[i] = rise[i] | fall[i];
      endcase
    end
  end

  // nmi pin has no both-edge or level mode
  assign nmi_edge = nmi_rise_i ? rise[icp_pkg::PIN_NMI]
                               : fall[icp_pkg::PIN_NMI];

  always_comb begin
    nmi_set = '0;
    nmi_set[icp_pkg::NMI_PIN]  = nmi_edge;
    nmi_set[icp_pkg::NMI_OSC]  = osc_stop_i;
    nmi_set[icp_pkg::NMI_WDT]  = wdt_err_i;
    nmi_set[icp_pkg::NMI_IWDT] = iwdt_err_i;
    nmi_set[icp_pkg::NMI_LVD1] = lvd1_i;
    nmi_set[icp_pkg::NMI_LVD2] = lvd2_i;
    nmi_set[icp_pkg::NMI_VBAT] = vbat_i;
  end

  always_comb begin
    set_vec = periph_req_i;
    for (int i = 0; i < icp_pkg::NUM_EXT; i++) begin
      set_vec[int'(icp_pkg::IRQ_VEC_BASE) + i] =
        periph_req_i[int'(icp_pkg::IRQ_VEC_BASE) + i] | ext_hit[i];
    end
    set_vec[icp_pkg::SWI_VEC] = periph_req_i[icp_pkg::SWI_VEC] |
                                sw_trigger_i;
    clr_vec = '0;
    if (irq_ack_i) begin
      clr_vec[irq_ack_vec_i] = 1'b1;
    end
  end

  // lowest enabled, implemented vector wins
  always_comb begin
    found = 1'b0;
    pick  = '0;
    for (int v = icp_pkg::NUM_VEC - 1; v >= 0; v--) begin
      if (st_reg.flags[v] && irq_en_i[v] && impl_mask[v]) begin
        found = 1'b1;
        pick  = icp_pkg::VEC_W'(v);
      end
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.div_cnt  = icp_pkg::DIV_W'(st_reg.div_cnt + 1'b1);
    st_next.tick     = (st_reg.div_cnt & div_mask) == div_mask;
    st_next.prev_lvl = flt_lvl;
    // set wins over a same-cycle acknowledge
    st_next.flags = ((st_reg.flags & ~clr_vec) | set_vec) & impl_mask;
    // no mask exists for these; only an explicit clear drops them
    st_next.nmi_flags = (st_reg.nmi_flags & ~nmi_clear_i) | nmi_set;
    st_next.nmi_req   = |st_next.nmi_flags;
    st_next.irq_valid = found;
    st_next.irq_vec   = pick;
    // undefined opcode outranks break, break outranks trap
    if (undef_i) begin
      st_next.exc = '{valid: 1'b1, code: icp_pkg::EXC_UNDEF,
                      num: '0};
    end else if (break_instruction_i) begin
      st_next.exc = '{valid: 1'b1, code: icp_pkg::EXC_BREAK,
                      num: '0};
    end else if (trap_i) begin
      st_next.exc = '{valid: 1'b1, code: icp_pkg::EXC_TRAP,
                      num: trap_num_i};
    end else begin
      st_next.exc = '{valid: 1'b0, code: icp_pkg::EXC_NONE, num: '0};
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg           <= '0;
      st_reg.prev_lvl  <= icp_pkg::PIN_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign irq_valid_o  = st_reg.irq_valid;
  assign irq_vec_o    = st_reg.irq_vec;
  assign nmi_o        = st_reg.nmi_req;
  assign nmi_status_o = st_reg.nmi_flags;
  assign exc_o        = st_reg.exc;
  assign pin_level_o  = st_reg.prev_lvl;

  a_nmi_osc_latch: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    osc_stop_i |=> nmi_status_o[icp_pkg::NMI_OSC] && nmi_o)
    else $error("oscillation stop did not raise nmi");

  a_div_period8: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    st_reg.tick && div_sel_i == icp_pkg::SMP_DIV8
      ##1 (div_sel_i == icp_pkg::SMP_DIV8 && !st_reg.tick)[*7]
      |=> st_reg.tick)
    else $error("divide-by-8 sample tick period wrong");

  a_ext_rise: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    ext_mode_i[1:0] == icp_pkg::DET_RISE && rise[0]
      |=> st_reg.flags[icp_pkg::IRQ_VEC_BASE])
    else $error("rising edge on pin 0 not flagged");

  a_ext_fall: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    ext_mode_i[1:0] == icp_pkg::DET_FALL && fall[0]
      |=> st_reg.flags[icp_pkg::IRQ_VEC_BASE])
    else $error("falling edge on pin 0 not flagged");

  a_ext_both: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    ext_mode_i[1:0] == icp_pkg::DET_BOTH && (rise[0] || fall[0])
      |=> st_reg.flags[icp_pkg::IRQ_VEC_BASE])
    else $error("edge on pin 0 not flagged in both-edge mode");

  a_ext_low: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    ext_mode_i[1:0] == icp_pkg::DET_LOW && !flt_lvl[0]
      |=> st_reg.flags[icp_pkg::IRQ_VEC_BASE])
    else $error("low level on pin 0 not held as request");

  a_sw_flag: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    sw_trigger_i |=> st_reg.flags[icp_pkg::SWI_VEC])
    else $error("software trigger lost");

  a_trap_num: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    trap_i && !undef_i && !break_instruction_i
      |=> exc_o.valid && exc_o.code == icp_pkg::EXC_TRAP
          && exc_o.num == $past(trap_num_i))
    else $error("trap exception or number wrong");

  a_undef_exc: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    undef_i |=> exc_o.valid && exc_o.code == icp_pkg::EXC_UNDEF)
    else $error("undefined opcode exception missing");

  a_ver_sdh: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    ver_ac && irq_valid_o |-> !(irq_vec_o inside
      {[icp_pkg::SDH_VEC_LO:icp_pkg::SDH_VEC_HI],
       [icp_pkg::SEC_VEC_LO:icp_pkg::SEC_VEC_HI]}))
    else $error("absent vector presented on version A or C");

  a_ver_can: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    ver_c && irq_valid_o |-> !(irq_vec_o inside
      {[icp_pkg::CAN_VEC_LO:icp_pkg::CAN_VEC_HI]}))
    else $error("absent vector presented on version C");

  a_impl_only: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    irq_valid_o |-> impl_mask[irq_vec_o] && $past(irq_en_i[pick]))
    else $error("unimplemented or disabled vector presented");

  a_nmi_pin_rise: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    nmi_rise_i && rise[icp_pkg::PIN_NMI]
      |=> nmi_status_o[icp_pkg::NMI_PIN])
    else $error("rising edge on nmi pin not latched");

  a_nmi_pin_fall: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !nmi_rise_i && fall[icp_pkg::PIN_NMI]
      |=> nmi_status_o[icp_pkg::NMI_PIN])
    else $error("falling edge on nmi pin not latched");

  a_nmi_clear: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    nmi_clear_i[icp_pkg::NMI_OSC] && !osc_stop_i
      |=> !nmi_status_o[icp_pkg::NMI_OSC])
    else $error("cleared oscillation stop status stayed set");

  a_exc_single: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !undef_i && !break_instruction_i && !trap_i |=> !exc_o.valid)
    else $error("exception shown without a request");

endmodule
`default_nettype wire

// ---- bench/icp_cpu_model.sv ----
// icp_cpu_model: cpu side that takes and acknowledges requests.
// assumes requests settle after each rising edge; acks launch just after one.
`timescale 1ns/1ps
`default_nettype none
module icp_cpu_model (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  // control
  input  wire logic       take_i,
  input  wire logic [3:0] delay_i,
  // request and acknowledge
  input  wire logic       irq_valid_i,
  input  wire logic [7:0] irq_vec_i,
  output logic            ack_o,
  output logic [7:0]      ack_vec_o,
  // record
  output int              acks_o,
  output logic [7:0]      last_vec_o
);
  int wait_cnt;
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      ack_vec_o <= 8'hA5;
      acks_o <= 0;
      last_vec_o <= 8'h00;
      wait_cnt <= 0;
    end else if (ack_o) begin
      // request drops two edges after ack; hold off meanwhile
      ack_o <= 1'b0;
      ack_vec_o <= ~ack_vec_o;
      wait_cnt <= -3;
    end else if (wait_cnt < 0) begin
      // released vector lines never repeat the last value
      ack_vec_o <= ~ack_vec_o;
      wait_cnt <= wait_cnt + 1;
    end else if (take_i && irq_valid_i && wait_cnt >= int'(delay_i)) begin
      ack_o <= 1'b1;
      ack_vec_o <= irq_vec_i;
      acks_o <= acks_o + 1;
      last_vec_o <= irq_vec_i;
      wait_cnt <= 0;
    end else begin
      ack_vec_o <= ~ack_vec_o;
      wait_cnt <= (take_i && irq_valid_i) ? wait_cnt + 1 : 0;
    end
  end
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// tb_top: self-checking bench for the interrupt controller.
// assumes icp_cpu_model acks requests; inputs change on falling edges.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic              ref_clk_i, rst_i, nmi_rise, nmi_pin, sw, ack;
  logic              trap, break_instruction, undef, valid, nmi, take;
  logic [1:0]        ver, div_sel;
  logic [3:0]        tnum, delay;
  logic [5:0]        src;
  logic [6:0]        clr, stat;
  logic [7:0]        pins, ack_vec, vec, last, vv;
  logic [8:0]        flt_en, lvl;
  logic [15:0]       mode;
  logic [255:0]      preq, en;
  logic [31:0]       rnd;
  icp_pkg::icp_exc_t exc;
  int                acks, mismatches, checks_done, a0, n, per;
  logic [7:0]        corner [10] = '{8'h28, 8'h2B, 8'h34, 8'h38, 8'h6F,
                                     8'h71, 8'h27, 8'h2C, 8'h39, 8'h6E};

  icp_top icp_top_inst (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .chip_ver_i(ver),
    .div_sel_i(div_sel), .filter_en_i(flt_en), .ext_mode_i(mode),
    .nmi_rise_i(nmi_rise), .external_irq_pins_i(pins),
    .nmi_pin_i(nmi_pin), .osc_stop_i(src[0]), .wdt_err_i(src[1]),
    .iwdt_err_i(src[2]), .lvd1_i(src[3]), .lvd2_i(src[4]),
    .vbat_i(src[5]), .nmi_clear_i(clr), .periph_req_i(preq),
    .irq_en_i(en), .sw_trigger_i(sw), .irq_ack_i(ack),
    .irq_ack_vec_i(ack_vec), .trap_i(trap), .trap_num_i(tnum),
    .break_instruction_i(break_instruction), .undef_i(undef), .irq_valid_o(valid),
    .irq_vec_o(vec), .nmi_o(nmi), .nmi_status_o(stat), .exc_o(exc),
    .pin_level_o(lvl));

  icp_cpu_model icp_cpu_model_inst (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .take_i(take),
    .delay_i(delay), .irq_valid_i(valid), .irq_vec_i(vec),
    .ack_o(ack), .ack_vec_o(ack_vec), .acks_o(acks), .last_vec_o(last));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // absent vectors per chip version
  function automatic logic vec_ok(input logic [7:0] v, input logic [1:0] c);
    logic ac;
    ac = (c == icp_pkg::VER_A) || (c == icp_pkg::VER_C);
    if (ac && ((v >= 8'h28 && v <= 8'h2B) || (v >= 8'h6F && v <= 8'h71)))
      return 1'b0;
    return !(c == icp_pkg::VER_C && v >= 8'h34 && v <= 8'h38);
  endfunction

  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk_i);
  endtask

  task automatic wait_acks(input int target);
    for (int i = 0; i < 40 && acks < target; i++) cyc(1);
    if (acks < target) begin
      check("ack wait", 0, 1);
      complete_run();
    end
  endtask

  task automatic wait_lvl(input int p, input logic v, input int lim);
    n = 0;
    while (lvl[p] !== v && n < lim) begin
      cyc(1);
      n++;
    end
    if (lvl[p] !== v) begin
      check("level wait", 0, 1);
      complete_run();
    end
  endtask

  task automatic set_pin(input int p, input logic v);
    if (p == 8) nmi_pin = v;
    else pins[p] = v;
  endtask

  task automatic clear_nmi(input int b);
    clr[b] = 1'b1;
    cyc(1);
    clr = 7'h00;
    cyc(2);
  endtask

  task automatic req_vec(input logic [7:0] v, input logic ok);
    a0 = acks;
    preq[v] = 1'b1;
    cyc(1);
    preq[v] = 1'b0;
    if (ok) wait_acks(a0 + 1);
    else cyc(15);
    check("vector acks", acks, a0 + 32'(ok));
    if (ok) check("vector", last, v);
  endtask

  initial begin
    {rst_i, take, ver, div_sel, flt_en} = {1'b1, 1'b1, 2'h1, 2'h0, 9'h000};
    {nmi_rise, nmi_pin, pins, src, clr} = {1'b0, 1'b1, 8'hFF, 6'h00, 7'h00};
    {sw, trap, tnum, break_instruction, undef, delay} = {1'b0, 1'b0, 4'h0, 1'b0, 1'b0, 4'h0};
    {mode, preq, en} = {16'hAAAA, 256'h0, {256{1'b1}}};
    {mismatches, checks_done, rnd} = {32'h0, 32'h0, 32'h00002E42};
    cyc(20);
    check("reset outputs", {valid, vec, nmi, stat, exc}, 24'h000000);
    check("reset levels", lvl, 9'h1FF);
    rst_i = 1'b0;
    cyc(2);
    $display("test reset done");
    // non-maskable: enables all off on purpose
    en = '0;
    for (int i = 0; i < 6; i++) begin
      src[i] = 1'b1;
      cyc(1);
      src[i] = 1'b0;
      cyc(1);
      check("nmi status", {nmi, stat}, {1'b1, 7'(2 << i)});
      clear_nmi(i + 1);
      check("nmi cleared", {nmi, stat}, 8'h00);
    end
    for (int r = 0; r < 2; r++) begin
      nmi_rise = r[0];
      nmi_pin = 1'b0;
      cyc(6);
      check("nmi pin fall", stat[0], !r[0]);
      nmi_pin = 1'b1;
      cyc(6);
      check("nmi pin rise", stat[0], 1'b1);
      clear_nmi(0);
    end
    en = '1;
    $display("test nmi done");
    for (int p = 0; p < 8; p++) begin
      delay = {2'h0, rnd[1:0]};
      rnd = lfsr(rnd);
      for (int m = 0; m < 4; m++) begin
        mode[2*p +: 2] = 2'(m);
        a0 = acks;
        pins[p] = 1'b0;
        cyc(20);
        check("raw level", lvl[p], 1'b0);
        pins[p] = 1'b1;
        cyc(15);
        if (m == icp_pkg::DET_LOW) check("low reqs", acks - a0 >= 2, 1);
        else check("edge reqs", acks - a0, (m == icp_pkg::DET_BOTH) ? 2 : 1);
        check("pin vector", last, 8'h40 + 8'(p));
      end
    end
    $display("test modes done");
    for (int p = 0; p < 9; p++) begin
      div_sel = 2'(p % 4);
      per = (p % 4 == 0) ? 1 : (p % 4 == 1) ? 8 : (p % 4 == 2) ? 32 : 64;
      flt_en[p] = 1'b1;
      if (p < 8) mode[2*p +: 2] = icp_pkg::DET_FALL;
      nmi_rise = 1'b0;
      a0 = acks;
      // a one-cycle glitch is never three equal samples
      set_pin(p, 1'b0);
      cyc(1);
      set_pin(p, 1'b1);
      cyc(4 * per + 8);
      check("glitch level", lvl[p], 1'b1);
      check("glitch reqs", acks + stat[0], a0);
      set_pin(p, 1'b0);
      wait_lvl(p, 1'b0, 3 * per + 10);
      check("filter delay", n >= 2*per + 1 && n <= 3*per + 4, 1);
      set_pin(p, 1'b1);
      wait_lvl(p, 1'b1, 3 * per + 10);
      cyc(10);
      check("filtered reqs", acks + stat[0], a0 + 1);
      clear_nmi(0);
      flt_en[p] = 1'b0;
    end
    $display("test filter done");
    for (int c = 0; c < 4; c++) begin
      ver = 2'(c);
      rst_i = 1'b1;
      cyc(2);
      rst_i = 1'b0;
      cyc(2);
      for (int i = 0; i < 16; i++) begin
        vv = (i < 10) ? corner[i] : rnd[7:0];
        rnd = lfsr(rnd);
        req_vec(vv, vec_ok(vv, ver));
      end
    end
    $display("test vectors done");
    take = 1'b0;
    a0 = acks;
    sw = 1'b1;
    preq[8'h30] = 1'b1;
    cyc(1);
    sw = 1'b0;
    preq[8'h30] = 1'b0;
    cyc(4);
    take = 1'b1;
    wait_acks(a0 + 1);
    check("soft vector", last, 8'h1B);
    wait_acks(a0 + 2);
    check("next vector", last, 8'h30);
    $display("test software done");
    for (int t = 0; t < 16; t++) begin
      trap = 1'b1;
      tnum = 4'(t);
      cyc(1);
      trap = 1'b0;
      check("trap exc", exc, {1'b1, icp_pkg::EXC_TRAP, 4'(t)});
      cyc(1);
      check("exc single", exc.valid, 1'b0);
    end
    break_instruction = 1'b1;
    cyc(1);
    break_instruction = 1'b0;
    check("break exc", {exc.valid, exc.code}, {1'b1, icp_pkg::EXC_BREAK});
    cyc(1);
    {undef, trap} = 2'h3;
    cyc(1);
    {undef, trap} = 2'h0;
    check("undef exc", {exc.valid, exc.code}, {1'b1, icp_pkg::EXC_UNDEF});
    cyc(2);
    $display("test exceptions done");
    complete_run();
  end
endmodule
`default_nettype wire
